// ===== verilog/digipot_map.svh
// device type code, opcodes, reset values and timing counts of the pot block
`ifndef DIGIPOT_MAP_SVH
`define DIGIPOT_MAP_SVH
// device type code in the address byte; the value is arbitrary
`define DEV_TYPE_ID 4'ha
`define OP_RD_WIPER 4'h9
`define OP_WR_WIPER 4'ha
`define OP_RD_PRESET 4'hb
`define OP_WR_PRESET 4'hc
`define OP_XFR_TO_WIPER 4'hd
`define OP_XFR_TO_PRESET 4'he
`define OP_GANG_TO_WIPER 4'h1
`define OP_GANG_TO_PRESET 4'h8
`define OP_INC_DEC 4'h2
`define OP_RD_STATUS 4'h5
`define WIPER_RESET 6'h00
`define PRESET_RESET 6'h00
`define NV_WRITE_TIME_MS 5
`define CLK_MHZ 100
`define NV_WRITE_CYCLES ((`NV_WRITE_TIME_MS) * 1000 * (`CLK_MHZ))
`endif

// ===== verilog/digipot_pkg.sv
// types shared by the pot block
package digipot_pkg;
  typedef logic [5:0] wiper_type;
  typedef enum logic [2:0] {
    ST_ADDR = 3'b000,
    ST_INSTR = 3'b001,
    ST_DATA = 3'b010,
    ST_INCDEC = 3'b011,
    ST_IGNORE = 3'b100,
    ST_DONE = 3'b101
  } frame_state_type;
endpackage

// ===== verilog/pin_sync_bus.sv
// carrier for the synchronised serial pins
`timescale 1ns/1ps
interface pin_sync_bus;
  logic cs_n;
  logic sck;
  logic si;
  logic [1:0] addr_pins;
  modport src (output cs_n, sck, si, addr_pins);
  modport dst (input cs_n, sck, si, addr_pins);
endinterface

// ===== verilog/pin_sync.sv
// two-flop synchroniser for the serial and address pins
`timescale 1ns/1ps
module pin_sync (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // raw pins
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic [1:0] i_addr_pins,
  // synchronised side
  pin_sync_bus.src o_bus
);
  logic [4:0] meta_r;
  logic [4:0] sync_r;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_r <= 5'h01;
      sync_r <= 5'h01;
    end else if (i_ce) begin
      meta_r <= {i_addr_pins, i_si, i_sck, i_cs_n};
      sync_r <= meta_r;
    end
  end

  assign o_bus.cs_n = sync_r[0];
  assign o_bus.sck = sync_r[1];
  assign o_bus.si = sync_r[2];
  assign o_bus.addr_pins = sync_r[4:3];
endmodule

// ===== verilog/digipot_core.sv
// serial command front end and register set of a quad digital pot
`timescale 1ns/1ps
`include "digipot_map.svh"
module digipot_core (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // serial pins (asynchronous)
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic [1:0] i_board_select,
  // serial output
  output logic o_so,
  output logic o_so_oe,
  // tap selects and status
  output logic [63:0] o_tap_sel [4],
  output logic o_write_in_progress_flag
);
  import digipot_pkg::*;

  pin_sync_bus sb ();
  pin_sync u_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_cs_n(i_cs_n),
    .i_sck(i_sck),
    .i_si(i_si),
    .i_addr_pins(i_board_select),
    .o_bus(sb.src)
  );

  frame_state_type state_r;
  logic sck_d_r;
  logic [7:0] shift_r;
  logic [2:0] bit_cnt_r;
  logic [3:0] opcode_r;
  logic [1:0] preset_idx_r;
  logic [1:0] pot_idx_r;
  logic [7:0] out_r;
  logic so_r;
  logic so_oe_r;
  wiper_type wiper_position [4];
  wiper_type preset_store [4][4];
  wiper_type nv_data_r [4];
  logic [3:0] nv_mask_r;
  logic [1:0] nv_idx_r;
  logic nv_pend_r;
  logic prog_busy_r;
  logic [31:0] prog_cnt_r;
  logic recall_r;
  logic [63:0] tap_r [4];

  // edges of the sampled serial clock, and the sampled chip select level
  wire sck_rise = sb.sck && !sck_d_r;
  wire sck_fall = !sb.sck && sck_d_r;
  wire cs_act = !sb.cs_n;
  wire [7:0] byte_in = {shift_r[6:0], sb.si};
  wire byte_done = sck_rise && (bit_cnt_r == 3'h7);
  // address byte check: type, zero bits, pin match
  wire addr_ok = (byte_in[7:4] == `DEV_TYPE_ID) &&
                 (byte_in[3:2] == 2'h0) &&
                 (byte_in[1:0] == sb.addr_pins);
  wire [3:0] op_in = byte_in[7:4];
  wire is_wr_preset = (opcode_r == `OP_WR_PRESET);
  wire is_wr_wiper = (opcode_r == `OP_WR_WIPER);
  wire [31:0] nv_limit = 32'(`NV_WRITE_CYCLES);

  // serial clock history
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) sck_d_r <= 1'b0;
    else if (i_ce) sck_d_r <= sb.sck;
  end

  // frame decoder: address, instruction, data, stepping
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= ST_ADDR;
      shift_r <= 8'h00;
      bit_cnt_r <= 3'h0;
      opcode_r <= 4'h0;
      preset_idx_r <= 2'h0;
      pot_idx_r <= 2'h0;
      out_r <= 8'h00;
      so_r <= 1'b0;
      so_oe_r <= 1'b0;
      recall_r <= 1'b1;
      nv_pend_r <= 1'b0;
      nv_mask_r <= 4'h0;
      nv_idx_r <= 2'h0;
      for (int p = 0; p < 4; p++) begin
        wiper_position[p] <= `WIPER_RESET;
        nv_data_r[p] <= `WIPER_RESET;
        for (int r = 0; r < 4; r++) preset_store[p][r] <= `PRESET_RESET;
      end
    end else if (i_ce) begin
      if (recall_r) begin
        recall_r <= 1'b0;
        for (int p = 0; p < 4; p++)
          wiper_position[p] <= preset_store[p][0];
      end
      if (!cs_act) begin
        // frame end: commit a pending preset save
        state_r <= ST_ADDR;
        bit_cnt_r <= 3'h0;
        so_oe_r <= 1'b0;
        if (nv_pend_r && !prog_busy_r) begin
          for (int p = 0; p < 4; p++)
            if (nv_mask_r[p]) preset_store[p][nv_idx_r] <= nv_data_r[p];
        end
        nv_pend_r <= 1'b0;
      end else begin
        if (sck_rise) begin
          shift_r <= byte_in;
          bit_cnt_r <= bit_cnt_r + 3'h1;
        end
        // serial output changes on the falling edge
        if (sck_fall && so_oe_r) begin
          so_r <= out_r[7];
          out_r <= {out_r[6:0], 1'b0};
        end
        case (state_r)
          ST_ADDR: if (byte_done)
            state_r <= addr_ok ? ST_INSTR : ST_IGNORE;
          ST_INSTR: if (byte_done) begin
            opcode_r <= op_in;
            preset_idx_r <= byte_in[3:2];
            pot_idx_r <= byte_in[1:0];
            state_r <= ST_DATA;
            case (op_in)
              `OP_RD_WIPER: begin
                out_r <= {2'h0, wiper_position[byte_in[1:0]]};
                so_oe_r <= 1'b1;
              end
              `OP_RD_PRESET: begin
                out_r <= {2'h0, preset_store[byte_in[1:0]][byte_in[3:2]]};
                so_oe_r <= 1'b1;
              end
              `OP_RD_STATUS: begin
                out_r <= {7'h00, prog_busy_r};
                so_oe_r <= 1'b1;
              end
              `OP_XFR_TO_WIPER: begin
                wiper_position[byte_in[1:0]] <=
                  preset_store[byte_in[1:0]][byte_in[3:2]];
                state_r <= ST_DONE;
              end
              `OP_GANG_TO_WIPER: begin
                for (int p = 0; p < 4; p++)
                  wiper_position[p] <= preset_store[p][byte_in[3:2]];
                state_r <= ST_DONE;
              end
              `OP_XFR_TO_PRESET, `OP_GANG_TO_PRESET: begin
                for (int p = 0; p < 4; p++) begin
                  nv_data_r[p] <= wiper_position[p];
                  nv_mask_r[p] <= (op_in == `OP_GANG_TO_PRESET) ||
                                  (byte_in[1:0] == 2'(p));
                end
                nv_idx_r <= byte_in[3:2];
                nv_pend_r <= !prog_busy_r;
                state_r <= ST_DONE;
              end
              `OP_INC_DEC: state_r <= ST_INCDEC;
              default: state_r <= ST_DATA;
            endcase
          end
          ST_DATA: if (byte_done) begin
            state_r <= ST_DONE;
            if (is_wr_wiper)
              wiper_position[pot_idx_r] <= byte_in[5:0];
            if (is_wr_preset) begin
              nv_data_r[pot_idx_r] <= byte_in[5:0];
              nv_mask_r <= 4'h1 << pot_idx_r;
              nv_idx_r <= preset_idx_r;
              nv_pend_r <= !prog_busy_r;
            end
          end
          ST_INCDEC: if (sck_rise) begin
            // each clock steps one tap, saturating at the ends
            if (sb.si && wiper_position[pot_idx_r] != 6'h3f)
              wiper_position[pot_idx_r] <=
                wiper_position[pot_idx_r] + 6'h01;
            else if (!sb.si && wiper_position[pot_idx_r] != 6'h00)
              wiper_position[pot_idx_r] <=
                wiper_position[pot_idx_r] - 6'h01;
          end
          ST_IGNORE: so_oe_r <= 1'b0;
          ST_DONE: ;
          default: state_r <= ST_ADDR;
        endcase
      end
    end
  end

  // programming cycle timer; the commit and the start share one edge
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prog_busy_r <= 1'b0;
      prog_cnt_r <= 32'h0;
    end else if (i_ce) begin
      if (!cs_act && nv_pend_r && !prog_busy_r) begin
        prog_busy_r <= 1'b1;
        prog_cnt_r <= 32'h0;
      end else if (prog_busy_r) begin
        if (prog_cnt_r == nv_limit - 32'h1) prog_busy_r <= 1'b0;
        else prog_cnt_r <= prog_cnt_r + 32'h1;
      end
    end
  end

  // one-hot tap decode, registered so outputs come from flops
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int p = 0; p < 4; p++) tap_r[p] <= 64'h1;
    end else if (i_ce) begin
      for (int p = 0; p < 4; p++)
        tap_r[p] <= 64'h1 << wiper_position[p];
    end
  end

  assign o_tap_sel = tap_r;
  assign o_so = so_r;
  assign o_so_oe = so_oe_r;
  assign o_write_in_progress_flag = prog_busy_r;
endmodule

// ===== tb/spi_host.sv
// host-side serial master model for the pot block
`timescale 1ns/1ps
module spi_host (
  // serial pins
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si,
  input wire logic i_so,
  input wire logic i_so_oe
);
  logic oe_seen;
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
    oe_seen = 1'b0;
  end
  // mode 0 frame: bits set while clock low; so read late in high phase
  task automatic frame(input logic [23:0] w, input int n,
                       output logic [7:0] rd);
    rd = 8'h00;
    oe_seen = 1'b0;
    #1 o_cs_n = 1'b0;
    #250;
    for (int i = 0; i < n; i++) begin
      o_si = w[23 - i]; // address byte first, msb first
      #62.5 o_sck = 1'b1;
      // a released line reads as the inverse of its last level
      #55 rd = {rd[6:0], i_so_oe ? i_so : ~i_so};
      oe_seen = oe_seen | i_so_oe;
      #7.5 o_sck = 1'b0;
    end
    #250 o_cs_n = 1'b1;
    o_si = ~o_si; // no stale data level left on the line
    #250;
  endtask
endmodule

// ===== tb/digipot_core_asserts.sv
// assertions on the pot block pins
`timescale 1ns/1ps
`include "digipot_map.svh"
module digipot_core_asserts (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // pins and outputs
  input wire logic i_cs_n,
  input wire logic o_so_oe,
  input wire logic [63:0] o_tap_sel [4],
  input wire logic o_write_in_progress_flag
);
  logic [3:0] hi_r;
  logic [19:0] busy_r;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // cycles since select went high, and length of the busy time
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hi_r <= 4'h0;
      busy_r <= 20'h0;
    end else begin
      hi_r <= !i_cs_n ? 4'h0 : hi_r + {3'h0, hi_r != 4'hf};
      busy_r <= o_write_in_progress_flag ? busy_r + 20'h1 : 20'h0;
    end
  end
  // select held high long enough for all commits to land
  sequence cs_idle;
    i_cs_n [*8];
  endsequence
  reset_taps_a:
    assert property ($rose(i_nrst) |-> o_tap_sel[0] == 64'h1
      && o_tap_sel[3] == 64'h1) else $error("taps not at zero");
  tap_onehot_a:
    assert property ($onehot(o_tap_sel[0]) && $onehot(o_tap_sel[1])
      && $onehot(o_tap_sel[2]) && $onehot(o_tap_sel[3]))
      else $error("tap select not one-hot");
  busy_bound_a:
    assert property (o_write_in_progress_flag |->
      busy_r < `NV_WRITE_CYCLES) else $error("busy too long");
  save_on_cs_a:
    assert property ($rose(o_write_in_progress_flag) |-> i_cs_n
      && hi_r inside {[4'h1:4'hc]}) else $error("save not at cs rise");
  flag_hold_a:
    assert property ($rose(o_write_in_progress_flag) |=>
      o_write_in_progress_flag [*8]) else $error("flag dropped early");
  oe_release_a:
    assert property (cs_idle |-> !o_so_oe) else $error("so driven idle");
  taps_quiet_a:
    assert property (cs_idle |=> $stable(o_tap_sel[0])
      && $stable(o_tap_sel[2])) else $error("tap moved while idle");
  freeze_state_a:
    assert property (!i_ce |=> $stable(o_write_in_progress_flag)
      && $stable(o_tap_sel[1])) else $error("state moved while frozen");
endmodule
bind digipot_core digipot_core_asserts chk (.i_clk(i_clk),
  .i_nrst(i_nrst), .i_ce(i_ce), .i_cs_n(i_cs_n), .o_so_oe(o_so_oe),
  .o_tap_sel(o_tap_sel),
  .o_write_in_progress_flag(o_write_in_progress_flag));

// ===== tb/testbench.sv
// self-checking bench of the pot block
`timescale 1ns/1ps
`include "digipot_map.svh"
module testbench;
  import digipot_pkg::*;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_ce = 1'b1;
  logic [1:0] bsel = 2'b00;
  logic cs_n, sck, si, so, so_oe, flag;
  logic [63:0] taps [4];
  logic [7:0] rd, addr, pat;
  logic [1:0] p, r;
  wiper_type w [4];
  wiper_type v;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  integer seed = 32'h64dd;
  always #5 i_clk = ~i_clk;
  spi_host host (.o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so),
    .i_so_oe(so_oe));
  digipot_core uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
    .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_board_select(bsel),
    .o_so(so), .o_so_oe(so_oe), .o_tap_sel(taps),
    .o_write_in_progress_flag(flag));
  function automatic logic [63:0] tap(input wiper_type x);
    return 64'h1 << x;
  endfunction
  // up/down steps saturate at both ends of the wiper range
  function automatic wiper_type steps(input wiper_type x,
                                      input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      if (b[i] && x != 6'h3f) x = x + 6'h1;
      else if (!b[i] && x != 6'h00) x = x - 6'h1;
    end
    return x;
  endfunction
  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmd(input logic [7:0] ins, input logic [7:0] d,
                     input int n);
    @(posedge i_clk);
    host.frame({addr, ins, d}, n, rd);
    repeat (12) @(posedge i_clk);
  endtask
  task automatic restart();
    @(posedge i_clk);
    #1 i_nrst = 1'b0;
    repeat (5) @(posedge i_clk);
    #1 i_nrst = 1'b1;
    repeat (20) @(posedge i_clk);
    for (int k = 0; k < 4; k++) chk("tap", 64'h1, taps[k]);
    chk("flag", 64'h0, flag);
  endtask
  task stop_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // hang guard, well above the run's length
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    bsel = 2'($random(seed));
    addr = {`DEV_TYPE_ID, 2'b00, bsel};
    restart();
    for (int k = 0; k < 4; k++) begin
      w[k] = 6'($random(seed));
      cmd({`OP_WR_WIPER, 2'b00, 2'(k)}, {2'b00, w[k]}, 24);
      chk("tap", tap(w[k]), taps[k]);
      cmd({`OP_RD_WIPER, 2'b00, 2'(k)}, 8'h00, 24);
      chk("rdw", {2'b00, w[k]}, rd);
    end
    // wrong type, then wrong select pins: whole frame ignored
    for (int b = 0; b < 2; b++) begin
      addr = b ? {`DEV_TYPE_ID, 2'b00, ~bsel} : 8'h60 | bsel;
      cmd({`OP_WR_WIPER, 4'h0}, {2'b00, ~w[0]}, 24);
      chk("tap", tap(w[0]), taps[0]);
      cmd({`OP_RD_WIPER, 4'h0}, 8'h00, 24);
      chk("oe", 64'h0, host.oe_seen);
    end
    addr = {`DEV_TYPE_ID, 2'b00, bsel};
    for (int t = 0; t < 2; t++) begin
      v = t ? 6'($random(seed)) : 6'h3e;
      pat = t ? 8'($random(seed)) : 8'hf0;
      cmd({`OP_WR_WIPER, 4'h2}, {2'b00, v}, 24);
      cmd({`OP_INC_DEC, 4'h2}, pat, 24);
      chk("step", tap(steps(v, pat)), taps[2]);
    end
    p = 2'($random(seed));
    r = 2'($random(seed));
    v = 6'($random(seed));
    cmd({`OP_WR_PRESET, r, p}, {2'b00, v}, 24);
    chk("flag", 64'h1, flag);
    @(posedge i_clk);
    #1 i_ce = 1'b0;
    // a whole frame while frozen must leave pot 1 alone
    cmd({`OP_WR_WIPER, 4'h1}, {2'b00, ~w[1]}, 24);
    chk("frz", tap(w[1]), taps[1]);
    @(posedge i_clk);
    #1 i_ce = 1'b1;
    cmd({`OP_RD_STATUS, 4'h1}, 8'h00, 24);
    chk("status", 64'h1, rd[0]);
    cmd({`OP_WR_PRESET, r, p}, {2'b00, ~v}, 24);
    cmd({`OP_RD_PRESET, r, p}, 8'h00, 24);
    chk("rdp", {2'b00, v}, rd);
    cmd({`OP_RD_PRESET, ~r[1], r[0], p}, 8'h00, 24);
    chk("rdp", 64'h0, rd);
    cmd({`OP_XFR_TO_WIPER, r, p}, 8'h00, 16);
    chk("xfr", tap(v), taps[p]);
    cmd({`OP_GANG_TO_WIPER, r, 2'b00}, 8'h00, 16);
    for (int k = 0; k < 4; k++)
      chk("gang", tap(k == p ? v : 6'h00), taps[k]);
    restart();
    stop_test();
  end
endmodule
